// file: design/xram_map_pkg.sv
/*
  Constants and types shared by the expanded RAM address mapper, its port checker and its bench.
  Assumes a single core clock domain and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none

package xram_map_pkg;

  localparam int unsigned AXI_ADDR_W = 12;

  // Printed register offsets are indices; each register sits at byte address index * 4.
  localparam logic [7:0] RAM_PAGE_CONTROL_IDX = 8'h85;
  localparam logic [7:0] DIRECT_BANK_CONTROL_IDX = 8'h86;
  localparam logic [7:0] SYSTEM_CONFIG_REG_IDX = 8'hbf;
  localparam logic [AXI_ADDR_W-1:0] RAM_PAGE_CONTROL_ADDR = {2'h0, RAM_PAGE_CONTROL_IDX, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] DIRECT_BANK_CONTROL_ADDR = {2'h0, DIRECT_BANK_CONTROL_IDX, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] SYSTEM_CONFIG_REG_ADDR = {2'h0, SYSTEM_CONFIG_REG_IDX, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ROUTE_STATUS_ADDR = 12'h000;

  localparam logic [7:0] RAM_PAGE_CONTROL_RST = 8'h00;
  localparam logic [7:0] DIRECT_BANK_CONTROL_RST = 8'h01;
  localparam logic [7:0] SYSTEM_CONFIG_REG_RST = 8'h02;

  localparam int unsigned ONCHIP_XRAM_ENABLE_BIT = 1;
  localparam int unsigned BANK_SWITCH_ENABLE_BIT = 7;
  localparam int unsigned BANK_SELECT_LSB = 0;
  localparam int unsigned PAGE_SELECT_LSB = 0;

  localparam int unsigned SCRATCH_BYTES = 256;
  localparam int unsigned XRAM_BYTES = 768;
  localparam logic [15:0] XRAM_LIMIT = 16'h0300;
  localparam logic [1:0] PAGE_OFFCHIP = 2'h3;
  localparam logic [1:0] BANK_WINDOW_TAG = 2'h1;
  localparam logic [9:0] XRAM_LOGICAL_BASE = 10'h100;
  localparam logic [9:0] XRAM_LOGICAL_END = 10'h300;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TGT_NONE, TGT_SCRATCH, TGT_XRAM, TGT_EXT} target_t;

endpackage : xram_map_pkg

`default_nettype wire

// file: design/byte_ram.sv
/*
  Byte-wide memory with synchronous write and asynchronous read.
  Assumes the caller keeps the address inside DEPTH.
*/
`default_nettype none

module byte_ram #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW = 8
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);

  logic [7:0] mem_q [DEPTH];

  assign rdata_out = mem_q[addr_in];

  // No reset: contents are undefined after power-up, as with any on-chip SRAM.
  always_ff @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem_q[addr_in] <= wdata_in;
    end
  end

endmodule : byte_ram

`default_nettype wire

// file: design/expanded_ram_address_mapper.sv
/*
  Expanded RAM address mapper: routes core external-move and direct accesses to the
  scratchpad, the 768-byte expanded RAM or off-chip memory, with an AXI4-Lite register slave.
  Assumes the core and the off-chip bus controller run on clk_in and answer in the same cycle.
*/
`default_nettype none

module expanded_ram_address_mapper
  import xram_map_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic dir_req_in,
  input wire logic dir_we_in,
  input wire logic [7:0] dir_addr_in,
  input wire logic [7:0] dir_wdata_in,
  output logic dir_ack_out,
  input wire logic xmove_req_in,
  output logic xmove_ready_out,
  input wire logic xmove_we_in,
  input wire logic xmove_use_pointer_in,
  input wire logic [15:0] pointer_16bit_in,
  input wire logic [7:0] index_register_in,
  input wire logic [7:0] port2_latch_in,
  input wire logic [7:0] xmove_wdata_in,
  output logic xmove_ack_out,
  output logic [7:0] core_rdata_out,
  output logic ext_req_out,
  output logic ext_we_out,
  output logic [15:0] ext_addr_out,
  output logic [7:0] ext_wdata_out,
  input wire logic [7:0] ext_rdata_in
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic onchip_xram_enable_q;
  logic [1:0] page_select_q;
  logic bank_switch_enable_q;
  logic [3:0] bank_select_q;
  logic aw_full_q;
  logic [AXI_ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [7:0] w_data_q;
  logic w_strb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic s1_valid_q;
  logic s1_dir_q;
  logic s1_we_q;
  target_t s1_tgt_q;
  logic [15:0] s1_addr_q;
  logic [7:0] s1_wdata_q;
  logic dir_ack_q;
  logic xmove_ack_q;
  logic [7:0] core_rdata_q;
  target_t last_tgt_q;
  logic [15:0] last_addr_q;

  // Reset is released through two flops so that its removal is clean on clk_in.
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;

  // Register bus decode.
  wire do_write = aw_full_q && w_full_q && !bvalid_q;
  wire wr_page_hit = aw_addr_q == RAM_PAGE_CONTROL_ADDR;
  wire wr_bank_hit = aw_addr_q == DIRECT_BANK_CONTROL_ADDR;
  wire wr_conf_hit = aw_addr_q == SYSTEM_CONFIG_REG_ADDR;
  wire wr_stat_hit = aw_addr_q == ROUTE_STATUS_ADDR;
  wire wr_mapped = wr_page_hit || wr_bank_hit || wr_conf_hit || wr_stat_hit;
  wire wr_en = do_write && w_strb0_q;
  wire ar_take = s_axi_arvalid_in && !rvalid_q;
  wire rd_page_hit = s_axi_araddr_in == RAM_PAGE_CONTROL_ADDR;
  wire rd_bank_hit = s_axi_araddr_in == DIRECT_BANK_CONTROL_ADDR;
  wire rd_conf_hit = s_axi_araddr_in == SYSTEM_CONFIG_REG_ADDR;
  wire rd_stat_hit = s_axi_araddr_in == ROUTE_STATUS_ADDR;
  wire rd_mapped = rd_page_hit || rd_bank_hit || rd_conf_hit || rd_stat_hit;
  wire [7:0] page_read = {6'h00, page_select_q};
  wire [7:0] bank_read = {bank_switch_enable_q, 3'h0, bank_select_q};
  wire [7:0] conf_read = {6'h00, onchip_xram_enable_q, 1'b0};
  wire [31:0] stat_read = {14'h0000, last_tgt_q, last_addr_q};
  wire [31:0] rd_mux = rd_page_hit ? {24'h000000, page_read} :
                       rd_bank_hit ? {24'h000000, bank_read} :
                       rd_conf_hit ? {24'h000000, conf_read} :
                       rd_stat_hit ? stat_read : 32'h00000000;

  assign s_axi_awready_out = !aw_full_q;
  assign s_axi_wready_out = !w_full_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // Address and data are held separately, so the master may offer them in either order.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      else if (do_write)
      begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid_in && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata_in[7:0];
        w_strb0_q <= s_axi_wstrb_in[0];
      end
      else if (do_write)
      begin
        w_full_q <= 1'b0;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_in)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_in)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // Control registers; only byte lane 0 carries them, the rest of the word reads zero.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      onchip_xram_enable_q <= SYSTEM_CONFIG_REG_RST[ONCHIP_XRAM_ENABLE_BIT];
      page_select_q <= RAM_PAGE_CONTROL_RST[PAGE_SELECT_LSB +: 2];
      bank_switch_enable_q <= DIRECT_BANK_CONTROL_RST[BANK_SWITCH_ENABLE_BIT];
      bank_select_q <= DIRECT_BANK_CONTROL_RST[BANK_SELECT_LSB +: 4];
    end
    else if (wr_en)
    begin
      if (wr_conf_hit)
      begin
        onchip_xram_enable_q <= w_data_q[ONCHIP_XRAM_ENABLE_BIT];
      end
      if (wr_page_hit)
      begin
        page_select_q <= w_data_q[PAGE_SELECT_LSB +: 2];
      end
      if (wr_bank_hit)
      begin
        bank_switch_enable_q <= w_data_q[BANK_SWITCH_ENABLE_BIT];
        bank_select_q <= w_data_q[BANK_SELECT_LSB +: 4];
      end
    end
  end

  // Direct access routing.
  wire dir_in_window = bank_switch_enable_q && dir_addr_in[7:6] == BANK_WINDOW_TAG;
  wire [9:0] dir_logical = {bank_select_q, dir_addr_in[5:0]};
  wire [9:0] dir_xram_off = dir_logical - XRAM_LOGICAL_BASE;
  wire dir_log_scratch = dir_logical < XRAM_LOGICAL_BASE;
  wire dir_log_xram = !dir_log_scratch && dir_logical < XRAM_LOGICAL_END;
  wire target_t dir_tgt = !dir_in_window ? TGT_SCRATCH :
                          dir_log_scratch ? TGT_SCRATCH :
                          dir_log_xram ? TGT_XRAM : TGT_NONE;
  wire [15:0] dir_phys = !dir_in_window ? {8'h00, dir_addr_in} :
                         dir_log_scratch ? {8'h00, dir_logical[7:0]} :
                         {6'h00, dir_xram_off};

  // External-move routing.
  wire ptr_onchip = onchip_xram_enable_q && pointer_16bit_in < XRAM_LIMIT;
  wire idx_onchip = onchip_xram_enable_q && page_select_q != PAGE_OFFCHIP;
  wire [15:0] idx_onchip_addr = {6'h00, page_select_q, index_register_in};
  wire [15:0] idx_offchip_addr = {port2_latch_in, index_register_in};
  wire target_t xmove_tgt = (xmove_use_pointer_in ? ptr_onchip : idx_onchip) ? TGT_XRAM : TGT_EXT;
  wire [15:0] xmove_phys = xmove_use_pointer_in ? pointer_16bit_in :
                           idx_onchip ? idx_onchip_addr : idx_offchip_addr;

  // Direct accesses win the shared memories; an external move waits for as long as dir_req_in is high.
  wire xmove_take = xmove_req_in && !dir_req_in;
  wire any_take = dir_req_in || xmove_take;
  wire target_t take_tgt = dir_req_in ? dir_tgt : xmove_tgt;
  wire [15:0] take_addr = dir_req_in ? dir_phys : xmove_phys;

  assign xmove_ready_out = !dir_req_in;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_valid_q <= 1'b0;
      s1_dir_q <= 1'b0;
      s1_we_q <= 1'b0;
      s1_tgt_q <= TGT_NONE;
      s1_addr_q <= 16'h0000;
      s1_wdata_q <= 8'h00;
      last_tgt_q <= TGT_NONE;
      last_addr_q <= 16'h0000;
    end
    else
    begin
      s1_valid_q <= any_take;
      if (any_take)
      begin
        s1_dir_q <= dir_req_in;
        s1_we_q <= dir_req_in ? dir_we_in : xmove_we_in;
        s1_tgt_q <= take_tgt;
        s1_addr_q <= take_addr;
        s1_wdata_q <= dir_req_in ? dir_wdata_in : xmove_wdata_in;
        last_tgt_q <= take_tgt;
        last_addr_q <= take_addr;
      end
    end
  end

  // Memories are written in the cycle after the request is taken.
  wire s1_scratch = s1_valid_q && s1_tgt_q == TGT_SCRATCH;
  wire s1_xram = s1_valid_q && s1_tgt_q == TGT_XRAM;
  wire [7:0] scratch_rdata;
  wire [7:0] xram_rdata;

  byte_ram #(.DEPTH(SCRATCH_BYTES), .AW(8)) scratch_ram (
    .clk_in(clk_in),
    .we_in(s1_scratch && s1_we_q),
    .addr_in(s1_addr_q[7:0]),
    .wdata_in(s1_wdata_q),
    .rdata_out(scratch_rdata)
  );

  byte_ram #(.DEPTH(XRAM_BYTES), .AW(10)) xram_ram (
    .clk_in(clk_in),
    .we_in(s1_xram && s1_we_q),
    .addr_in(s1_addr_q[9:0]),
    .wdata_in(s1_wdata_q),
    .rdata_out(xram_rdata)
  );

  assign ext_req_out = s1_valid_q && s1_tgt_q == TGT_EXT;
  assign ext_we_out = s1_we_q;
  assign ext_addr_out = s1_addr_q;
  assign ext_wdata_out = s1_wdata_q;

  // Unbacked banked locations read zero, since no memory is selected for them.
  wire [7:0] rd_sel = s1_scratch ? scratch_rdata :
                      s1_xram ? xram_rdata :
                      ext_req_out ? ext_rdata_in : 8'h00;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_ack_q <= 1'b0;
      xmove_ack_q <= 1'b0;
      core_rdata_q <= 8'h00;
    end
    else
    begin
      dir_ack_q <= s1_valid_q && s1_dir_q;
      xmove_ack_q <= s1_valid_q && !s1_dir_q;
      if (s1_valid_q && !s1_we_q)
      begin
        core_rdata_q <= rd_sel;
      end
    end
  end

  assign dir_ack_out = dir_ack_q;
  assign xmove_ack_out = xmove_ack_q;
  assign core_rdata_out = core_rdata_q;

endmodule : expanded_ram_address_mapper

`default_nettype wire

// file: verification/xram_map_chk.sv
/*
  Port checker for the expanded RAM address mapper.
  Assumes no request arrives until the synchronised reset has been released.
*/
`default_nettype none

module xram_map_chk
  import xram_map_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic dir_req_in,
  input wire logic dir_ack_out,
  input wire logic xmove_req_in,
  input wire logic xmove_use_pointer_in,
  input wire logic [15:0] pointer_16bit_in,
  input wire logic [7:0] index_register_in,
  input wire logic [7:0] port2_latch_in,
  input wire logic xmove_ack_out,
  input wire logic ext_req_out,
  input wire logic [15:0] ext_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_take;
    xmove_req_in && !dir_req_in;
  endsequence
  sequence s_ptr_high;
    s_take ##0 (xmove_use_pointer_in && pointer_16bit_in >= XRAM_LIMIT);
  endsequence

  AST_DIR_ACK: assert property (dir_req_in |-> ##2 dir_ack_out)
    else $error("direct ack missing");
  AST_XMV_ACK: assert property (s_take |-> ##2 xmove_ack_out)
    else $error("external move ack missing");
  AST_DIR_NO_XACK: assert property (dir_req_in |-> ##2 !xmove_ack_out)
    else $error("external move acked while direct access had priority");
  AST_PTR_HIGH: assert property (s_ptr_high |=> ext_req_out &&
    ext_addr_out == $past(pointer_16bit_in)) else $error("high pointer stayed on chip");
  AST_IDX_EXT: assert property (s_take ##0 !xmove_use_pointer_in ##1 ext_req_out |->
    ext_addr_out == {$past(port2_latch_in), $past(index_register_in)})
    else $error("indexed off-chip address wrong");
  AST_DIR_ONCHIP: assert property (dir_req_in |=> !ext_req_out)
    else $error("direct access went off chip");
  AST_EXT_CAUSE: assert property (ext_req_out |-> $past(xmove_req_in) && !$past(dir_req_in))
    else $error("off-chip access without external move");
  AST_WR_RESP: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write response late");
  AST_RD_RESP: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response late");
endmodule : xram_map_chk

bind expanded_ram_address_mapper xram_map_chk chk (.*);

`default_nettype wire

// file: verification/ext_mem_model.sv
/*
  Off-chip data memory answering the mapper's external bus.
  Assumes single-cycle access pulses on the core clock.
*/
`default_nettype none

module ext_mem_model
(
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] m [65536];
  logic [7:0] last_q = 8'h00;
  // Idle bus shows the inverse of the last byte, so a late sample cannot pass by luck.
  assign rdata_out = req_in ? m[addr_in] : ~last_q;
  always_ff @(posedge clk_in)
  begin
    if (req_in && we_in)
      m[addr_in] <= wdata_in;
    if (req_in)
      last_q <= m[addr_in];
  end
endmodule : ext_mem_model

`default_nettype wire

// file: verification/expanded_ram_address_mapper_tb.sv
/*
  Self-checking bench for the expanded RAM address mapper.
  Assumes the off-chip memory model and the port checker bound to the design.
*/
`default_nettype none

module expanded_ram_address_mapper_tb
  import xram_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Both response readies stay high, so each answer is taken at the first edge that shows it.
  logic clk_in = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h1, arv = 1'h0;
  logic rready = 1'h1, dreq = 1'h0, xreq = 1'h0, we = 1'h0, ptr = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, dack, xack, ereq, ewe, xrdy;
  logic [1:0] bresp, rresp, bres;
  logic [15:0] a16 = 16'h0, eaddr;
  logic [7:0] wd = 8'h00, crd, ewd, erd;
  logic [15:0] pl [4] = '{16'h0000, 16'h02ff, 16'h0300, 16'hffff};
  int n_errors = 0, tests_run = 0;

  expanded_ram_address_mapper dut (.clk_in(clk_in), .rst_n_in(rst_n),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'h1), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arready),
    .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .dir_req_in(dreq), .dir_we_in(we),
    .dir_addr_in(a16[7:0]), .dir_wdata_in(wd), .dir_ack_out(dack), .xmove_req_in(xreq),
    .xmove_ready_out(xrdy), .xmove_we_in(we), .xmove_use_pointer_in(ptr),
    .pointer_16bit_in(a16), .index_register_in(a16[7:0]), .port2_latch_in(a16[15:8]),
    .xmove_wdata_in(wd), .xmove_ack_out(xack), .core_rdata_out(crd), .ext_req_out(ereq),
    .ext_we_out(ewe), .ext_addr_out(eaddr), .ext_wdata_out(ewd), .ext_rdata_in(erd));
  ext_mem_model pm (.clk_in(clk_in), .req_in(ereq), .we_in(ewe), .addr_in(eaddr),
    .wdata_in(ewd), .rdata_out(erd));

  function automatic logic [15:0] page_addr(logic [1:0] pg, logic [15:0] a);
    return (pg == PAGE_OFFCHIP) ? a : {6'h00, pg, a[7:0]};
  endfunction : page_addr

  function automatic logic [7:0] bank_exp(logic [9:0] l, logic [7:0] v);
    return (l >= XRAM_LOGICAL_END) ? 8'h00 : v;
  endfunction : bank_exp

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awv <= 1'h1;
    wv <= 1'h1;
    do
    begin
      @(posedge clk_in);
      if (awv && awready)
        awv <= 1'h0;
      if (wv && wready)
        wv <= 1'h0;
    end
    while (!bvalid);
    bres = bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arv <= 1'h1;
    do
    begin
      @(posedge clk_in);
      if (arv && arready)
        arv <= 1'h0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd

  // The core holds its qualifiers until the next call, so they stay valid past the taking edge.
  task automatic core(input logic d, input logic w, input logic p, input logic [15:0] a,
                      input logic [7:0] v, output logic [7:0] q);
    dreq <= d;
    xreq <= !d;
    we <= w;
    ptr <= p;
    a16 <= a;
    wd <= v;
    @(posedge clk_in);
    chk("xmove ready", xrdy, !d);
    dreq <= 1'h0;
    xreq <= 1'h0;
    do
    begin
      @(posedge clk_in);
    end
    while (!(dack || xack));
    chk("ack kind", dack, d);
    q = crd;
  endtask : core

  initial
  begin
    forever #50 clk_in = ~clk_in;
  end

  initial
  begin
    #2000000;
    n_errors++;
    results();
  end

  initial
  begin : main
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] q, v;
    logic [15:0] a;
    logic [9:0] l;
    void'($urandom(2381));
    repeat (5) @(posedge clk_in);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk_in);
    rd(SYSTEM_CONFIG_REG_ADDR, d, r);
    chk("config", d, 32'h00000002);
    chk("config resp", r, RESP_OKAY);
    rd(RAM_PAGE_CONTROL_ADDR, d, r);
    chk("page", d, 32'h00000000);
    rd(DIRECT_BANK_CONTROL_ADDR, d, r);
    chk("bank", d, 32'h00000001);
    rd(12'h004, d, r);
    chk("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped data", d, 32'h00000000);
    wr(12'h008, 8'hff);
    chk("wr unmapped", bres, RESP_SLVERR);
    for (int i = 0; i < 8; i++)
    begin
      a = (i < 4) ? pl[i] : 16'($urandom_range(1023));
      v = 8'($urandom);
      core(1'h0, 1'h1, 1'h1, a, v, q);
      core(1'h0, 1'h0, 1'h1, a, 8'h00, q);
      chk("ptr read", q, v);
      if (a >= XRAM_LIMIT)
        chk("ptr offchip", pm.m[a], v);
    end
    a = 16'($urandom_range(767));
    core(1'h0, 1'h1, 1'h1, a, 8'h3c, q);
    wr(SYSTEM_CONFIG_REG_ADDR, 8'h00);
    chk("wr resp", bres, RESP_OKAY);
    rd(SYSTEM_CONFIG_REG_ADDR, d, r);
    chk("config off", d, 32'h00000000);
    core(1'h0, 1'h1, 1'h1, a, 8'hc3, q);
    chk("off mem", pm.m[a], 8'hc3);
    core(1'h0, 1'h0, 1'h1, a, 8'h00, q);
    chk("off read", q, 8'hc3);
    rd(ROUTE_STATUS_ADDR, d, r);
    chk("status", d, {14'h0000, TGT_EXT, a});
    core(1'h0, 1'h1, 1'h0, {8'h01, a[7:0]}, 8'h5a, q);
    chk("idx off", pm.m[{8'h01, a[7:0]}], 8'h5a);
    wr(SYSTEM_CONFIG_REG_ADDR, 8'h02);
    core(1'h0, 1'h0, 1'h1, a, 8'h00, q);
    chk("on read", q, 8'h3c);
    for (int pg = 0; pg < 4; pg++)
    begin
      a = {8'h80 | 8'($urandom), 8'($urandom)};
      v = 8'($urandom);
      wr(RAM_PAGE_CONTROL_ADDR, 8'(pg));
      core(1'h0, 1'h1, 1'h0, a, v, q);
      core(1'h0, 1'h0, 1'h0, a, 8'h00, q);
      chk("idx read", q, v);
      core(1'h0, 1'h0, 1'h1, page_addr(2'(pg), a), 8'h00, q);
      chk("page map", q, v);
    end
    core(1'h1, 1'h1, 1'h0, 16'h0045, 8'ha5, q);
    wr(DIRECT_BANK_CONTROL_ADDR, 8'h81);
    core(1'h1, 1'h0, 1'h0, 16'h0045, 8'h00, q);
    chk("bank one", q, 8'ha5);
    wr(DIRECT_BANK_CONTROL_ADDR, 8'h05);
    core(1'h1, 1'h0, 1'h0, 16'h0045, 8'h00, q);
    chk("bank off", q, 8'ha5);
    for (int b = 0; b < 16; b++)
    begin
      l = {4'(b), 6'($urandom)};
      v = 8'($urandom);
      wr(DIRECT_BANK_CONTROL_ADDR, 8'h80 | 8'(b));
      core(1'h1, 1'h1, 1'h0, {10'h001, l[5:0]}, v, q);
      core(1'h1, 1'h0, 1'h0, {10'h001, l[5:0]}, 8'h00, q);
      chk("banked", q, bank_exp(l, v));
      wr(DIRECT_BANK_CONTROL_ADDR, 8'(b));
      if (l < XRAM_LOGICAL_END)
      begin
        a = (l < XRAM_LOGICAL_BASE) ? {8'h00, l[7:0]} : {6'h00, l - XRAM_LOGICAL_BASE};
        core(l < XRAM_LOGICAL_BASE, 1'h0, 1'h1, a, 8'h00, q);
        chk("physical", q, v);
      end
    end
    results();
  end
endmodule : expanded_ram_address_mapper_tb

`default_nettype wire
